// ### src/css_pkg.sv
// Purpose: Constants and types for the configuration scheme select front end.
// Assumes: Single 25 MHz reference clock; strap pins are static around sampling.
// Notes:   Times are given in their own unit and turned into cycle counts here.
//
// Summary of operation
// [R1] Strap 000 picks the 32-bit stream port, 101 the 16-bit port, 110 the 8-bit port.
// [R2] Strap 111 is JTAG, 001 fast quad flash, 011 normal quad flash, 100 card boot.
// [R3] An active JTAG request wins over the strap unless security has disabled JTAG.
// [R4] Passive schemes are mastered by the host; active schemes are mastered by us.
// [R5] The stream port back-pressures through ready; the host holds words under valid.
// [R6] The 8-bit port uses dedicated pins; the 16/32-bit pins are freed in user mode.
// [R7] Flash boot starts with three-byte addressing and then moves to four-byte.
// [R8] Normal flash mode waits 10 ms before starting; fast mode starts at once.
// [R9] In fast mode the board must release the flash from reset no later than us.
// [R10] A flash that does not answer its first access ends the attempt as missing.
// [R11] PCIe initial load fetches the periphery from flash, trains, then takes the core.
// [R12] In user mode a new core image may arrive over the trained link without periphery.
// [R13] The strap is sampled once per attempt and the decoded scheme is held throughout.
package css_pkg;

    localparam logic [2:0] CSS_SEL_X32    = 3'h0;
    localparam logic [2:0] CSS_SEL_FAST   = 3'h1;
    localparam logic [2:0] CSS_SEL_NORMAL = 3'h3;
    localparam logic [2:0] CSS_SEL_CARD   = 3'h4;
    localparam logic [2:0] CSS_SEL_X16    = 3'h5;
    localparam logic [2:0] CSS_SEL_X8     = 3'h6;
    localparam logic [2:0] CSS_SEL_JTAG   = 3'h7;

    // Clock rate and timing.
    localparam int CSS_CLK_HZ        = 25_000_000;
    localparam int CSS_WAIT_MS       = 10;
    localparam int CSS_WAIT_CYC      = CSS_CLK_HZ / 1000 * CSS_WAIT_MS;
    localparam int CSS_RESP_TIMEOUT  = 64;

    // Scheme decode result, one-hot.
    typedef enum logic [7:0] {
        CSS_SCH_NONE   = 8'h01,
        CSS_SCH_X32    = 8'h02,
        CSS_SCH_X16    = 8'h04,
        CSS_SCH_X8     = 8'h08,
        CSS_SCH_JTAG   = 8'h10,
        CSS_SCH_FAST   = 8'h20,
        CSS_SCH_NORMAL = 8'h40,
        CSS_SCH_CARD   = 8'h80
    } css_scheme_t;

    // Attempt sequencer, one-hot.
    typedef enum logic [8:0] {
        CSS_ST_IDLE    = 9'h001,
        CSS_ST_WAIT    = 9'h002,
        CSS_ST_PROBE   = 9'h004,
        CSS_ST_FW3     = 9'h008,
        CSS_ST_BODY4   = 9'h010,
        CSS_ST_TRAIN   = 9'h020,
        CSS_ST_STREAM  = 9'h040,
        CSS_ST_USER    = 9'h080,
        CSS_ST_FAIL    = 9'h100
    } css_state_t;

    // Flash side command bundle.
    typedef struct packed {
        logic req;
        logic addr4;
        logic boot_rd;
    } css_flash_cmd_t;

    // Status bundle.
    typedef struct packed {
        logic user_mode;
        logic failed;
        logic mem_missing;
        logic host_master;
        logic gpio_released;
    } css_status_t;

endpackage : css_pkg

// ### src/css_fifo.sv
`timescale 1ns/1ps
// Purpose: Small valid/ready FIFO for configuration stream words.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Ready on the fill side is only high while a slot is free.
module css_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // Pointer and fill count update.
    always_comb begin
        push  = in_valid && (cnt_q != (AW+1)'(DEPTH));
        pop   = out_ready && (cnt_q != '0);
        wr_d  = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d  = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage has no reset; words are only read once written.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
endmodule : css_fifo

// ### src/css_top.sv
`timescale 1ns/1ps
// Purpose: Decode the scheme strap and sequence one configuration attempt.
// Assumes: Strap, JTAG request and flash answers are synchronous to ref_clk.
// Notes:   Stream words are 32 bits; narrower modes use the low lanes.
module css_top #(
    parameter int WAIT_CYC  = css_pkg::CSS_WAIT_CYC,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic [2:0]          scheme_select_strap,
    input  wire logic                reconfig_req,
    input  wire logic                jtag_active,
    input  wire logic                jtag_disabled,
    input  wire logic                flash_ack,
    input  wire logic                fw_loaded,
    input  wire logic                periph_done,
    input  wire logic                pcie_link_up,
    input  wire logic                image_done,
    input  wire logic                core_update_req,
    input  wire logic                stream_cfg_valid,
    input  wire logic [31:0]         stream_cfg_word,
    output logic                     stream_cfg_ready,
    output logic                     word_valid,
    input  wire logic                word_ready,
    output logic [31:0]              word_data,
    output css_pkg::css_scheme_t     scheme,
    output css_pkg::css_flash_cmd_t  flash_cmd,
    output css_pkg::css_status_t     status
);
    import css_pkg::*;

    // One counter serves the power-up wait and the probe timeout, so it must hold the larger.
    localparam int CNT_MAX = (WAIT_CYC > CSS_RESP_TIMEOUT) ? WAIT_CYC : CSS_RESP_TIMEOUT;
    localparam int CW      = $clog2(CNT_MAX + 1) + 1;

    css_state_t     st_q, st_d;
    css_scheme_t    sch_q, sch_d, dec;
    logic [CW-1:0]  cnt_q, cnt_d;
    css_flash_cmd_t fc_q, fc_d;
    css_status_t    stat_q, stat_d;
    logic           rdy_q, rdy_d;
    logic           fin_ready, fout_valid;
    logic [31:0]    fout_data, in_word;
    logic           take;

    // ------------------------------------------------------------
    // Strap decode
    // ------------------------------------------------------------
    // Decode the strap, letting JTAG override.
    always_comb begin
        // [R1] [R2] strap table
        case (scheme_select_strap)
            CSS_SEL_X32:    dec = CSS_SCH_X32;
            CSS_SEL_X16:    dec = CSS_SCH_X16;
            CSS_SEL_X8:     dec = CSS_SCH_X8;
            CSS_SEL_JTAG:   dec = CSS_SCH_JTAG;
            CSS_SEL_FAST:   dec = CSS_SCH_FAST;
            CSS_SEL_NORMAL: dec = CSS_SCH_NORMAL;
            CSS_SEL_CARD:   dec = CSS_SCH_CARD;
            default:        dec = CSS_SCH_NONE;
        endcase
        // [R3] JTAG precedence
        if (jtag_active && !jtag_disabled) begin
            dec = CSS_SCH_JTAG;
        end
    end

    // ------------------------------------------------------------
    // Stream path
    // ------------------------------------------------------------
    // Narrow modes carry their data in the low lanes; upper lanes forced low.
    always_comb begin
        case (sch_q)
            CSS_SCH_X16: in_word = {16'h0000, stream_cfg_word[15:0]};
            CSS_SCH_X8:  in_word = {24'h00_0000, stream_cfg_word[7:0]};
            default:     in_word = stream_cfg_word;
        endcase
    end

    // [R5] backpressure via ready
    assign take = (st_q == CSS_ST_STREAM) && rdy_q && stream_cfg_valid;

    css_fifo #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .in_valid  (take),
        .in_ready  (fin_ready),
        .in_data   (in_word),
        .out_valid (fout_valid),
        .out_ready (word_ready),
        .out_data  (fout_data)
    );

    // ------------------------------------------------------------
    // Attempt sequencer
    // ------------------------------------------------------------
    // Next state for the attempt; all outputs except word_valid and word_data are registered below.
    always_comb begin
        st_d   = st_q;
        sch_d  = sch_q;
        cnt_d  = cnt_q;
        fc_d   = '0;
        stat_d = stat_q;
        case (st_q)
            CSS_ST_IDLE: begin
                // [R13] sample strap once
                sch_d  = dec;
                stat_d = '0;
                cnt_d  = '0;
                // [R4] who masters the link
                stat_d.host_master = (dec == CSS_SCH_X32) || (dec == CSS_SCH_X16)
                                   || (dec == CSS_SCH_X8) || (dec == CSS_SCH_JTAG);
                // [R8] wait only in normal mode
                if (dec == CSS_SCH_NORMAL) begin
                    st_d = CSS_ST_WAIT;
                end else if (dec == CSS_SCH_FAST || dec == CSS_SCH_CARD) begin
                    st_d = CSS_ST_PROBE;
                end else if (dec != CSS_SCH_NONE) begin
                    st_d = CSS_ST_STREAM;
                end else begin
                    st_d = CSS_ST_FAIL;
                end
            end
            CSS_ST_WAIT: begin
                // [R8] 10 ms delay
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CW'(WAIT_CYC - 1)) begin
                    cnt_d = '0;
                    st_d  = CSS_ST_PROBE;
                end
            end
            CSS_ST_PROBE: begin
                // [R9] fast mode relies on flash already out of reset
                fc_d.req     = 1'b1;
                fc_d.boot_rd = 1'b1;
                cnt_d        = cnt_q + 1'b1;
                if (flash_ack) begin
                    st_d  = CSS_ST_FW3;
                    cnt_d = '0;
                end else if (cnt_q == CW'(CSS_RESP_TIMEOUT - 1)) begin
                    // [R10] missing memory
                    stat_d.mem_missing = 1'b1;
                    st_d               = CSS_ST_FAIL;
                end
            end
            CSS_ST_FW3: begin
                // [R7] three-byte firmware read
                fc_d.req     = 1'b1;
                fc_d.boot_rd = 1'b1;
                if (fw_loaded) begin
                    st_d = CSS_ST_BODY4;
                end
            end
            CSS_ST_BODY4: begin
                // [R7] four-byte addressing
                fc_d.req   = 1'b1;
                fc_d.addr4 = 1'b1;
                // [R11] periphery from flash first
                if (periph_done && sch_q != CSS_SCH_CARD) begin
                    st_d = CSS_ST_TRAIN;
                end else if (image_done) begin
                    st_d = CSS_ST_USER;
                end
            end
            CSS_ST_TRAIN: begin
                // [R11] train then take core over PCIe
                if (pcie_link_up) begin
                    st_d               = CSS_ST_STREAM;
                    stat_d.host_master = 1'b1;
                end
            end
            CSS_ST_STREAM: begin
                if (image_done) begin
                    st_d = CSS_ST_USER;
                end
            end
            CSS_ST_USER: begin
                stat_d.user_mode   = 1'b1;
                // [R6] free shared pins for 16/32-bit modes
                stat_d.gpio_released = (sch_q == CSS_SCH_X16) || (sch_q == CSS_SCH_X32);
                // [R12] core update over live link
                if (core_update_req && pcie_link_up) begin
                    st_d             = CSS_ST_STREAM;
                    stat_d.user_mode = 1'b0;
                end else if (reconfig_req) begin
                    st_d = CSS_ST_IDLE;
                end
            end
            CSS_ST_FAIL: begin
                stat_d.failed = 1'b1;
                if (reconfig_req) begin
                    st_d = CSS_ST_IDLE;
                end
            end
            default: st_d = CSS_ST_IDLE;
        endcase
        // [R5] ready only in stream phase with room, registered
        rdy_d = (st_d == CSS_ST_STREAM) && fin_ready && !(take && rdy_q);
    end

    // Register the sequencer and every top-level output except word_valid and word_data, which come from the FIFO.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q   <= CSS_ST_IDLE;
            sch_q  <= CSS_SCH_NONE;
            cnt_q  <= '0;
            fc_q   <= '0;
            stat_q <= '0;
            rdy_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            sch_q  <= sch_d;
            cnt_q  <= cnt_d;
            fc_q   <= fc_d;
            stat_q <= stat_d;
            rdy_q  <= rdy_d;
        end
    end

    assign stream_cfg_ready = rdy_q;
    assign scheme           = sch_q;
    assign flash_cmd        = fc_q;
    assign status           = stat_q;
    assign word_valid       = fout_valid;
    assign word_data        = fout_data;
endmodule : css_top

// ### tb/css_assertions.sv
// Purpose: Port checks for the scheme select front end.
// Assumes: The bench shortens the flash wait to ten cycles.
// Notes:   Delay bounds below are worked out for that short wait.
`timescale 1ns/1ps
module css_checker
    import css_pkg::*;
#(
    parameter int WAIT_CYC   = 10,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic           ref_clk,
    input wire logic           rst_b,
    input wire logic           reconfig_req,
    input wire logic           stream_cfg_valid,
    input wire logic [31:0]    stream_cfg_word,
    input wire logic           stream_cfg_ready,
    input wire logic           word_valid,
    input wire logic [31:0]    word_data,
    input css_pkg::css_scheme_t    scheme,
    input css_pkg::css_flash_cmd_t flash_cmd,
    input css_pkg::css_status_t    status
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_ready_drop: assert property (
        stream_cfg_valid && stream_cfg_ready |=> !stream_cfg_ready)
        else $error("ready stayed high after a taken word");
    a_word_pass: assert property (
        scheme == CSS_SCH_X32 && stream_cfg_valid && stream_cfg_ready && !word_valid
        |=> word_valid && word_data == $past(stream_cfg_word))
        else $error("taken word did not appear at the output");
    a_lane_zero: assert property (
        word_valid && scheme inside {CSS_SCH_X16, CSS_SCH_X8} |-> word_data[31:16] == 16'h0000
        && (scheme != CSS_SCH_X8 || word_data[15:8] == 8'h00))
        else $error("upper lanes not zero in a narrow mode");
    a_scheme_hold: assert property (
        scheme != CSS_SCH_NONE && !reconfig_req && !$past(reconfig_req)
        && !$past(reconfig_req, 2) |=> $stable(scheme))
        else $error("scheme changed within an attempt");
    a_passive_quiet: assert property (
        scheme inside {CSS_SCH_X32, CSS_SCH_X16, CSS_SCH_X8, CSS_SCH_JTAG} |-> !flash_cmd.req)
        else $error("flash accessed in a passive scheme");
    a_addr_order: assert property (
        $rose(flash_cmd.addr4) |-> $past(flash_cmd.boot_rd) && !flash_cmd.boot_rd)
        else $error("four-byte phase not preceded by the boot read");
    a_fast_start: assert property (
        $rose(scheme == CSS_SCH_FAST) |-> ##[0:3] flash_cmd.req)
        else $error("fast mode did not access the flash at once");
    a_normal_wait: assert property (
        $rose(scheme == CSS_SCH_NORMAL) |-> !flash_cmd.req [*8] ##[1:8] flash_cmd.req)
        else $error("normal mode wait has the wrong length");
    a_gpio_user: assert property (
        status.gpio_released |-> status.user_mode && scheme inside {CSS_SCH_X16, CSS_SCH_X32})
        else $error("stream pins freed outside user mode");

    c_word: cover property (stream_cfg_valid && stream_cfg_ready);
    c_user: cover property ($rose(status.user_mode));
    c_missing: cover property ($rose(status.mem_missing));
endmodule // css_checker

bind css_top css_checker #(.WAIT_CYC(WAIT_CYC), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .reconfig_req(reconfig_req),
    .stream_cfg_valid(stream_cfg_valid), .stream_cfg_word(stream_cfg_word),
    .stream_cfg_ready(stream_cfg_ready), .word_valid(word_valid), .word_data(word_data),
    .scheme(scheme), .flash_cmd(flash_cmd), .status(status));

// ### tb/css_flash_model.sv
// Purpose: Quad flash partner answering probes and the firmware read.
// Assumes: The part leaves reset no later than the device.
// Notes:   With present low the part never answers, as a missing flash.
`timescale 1ns/1ps
module css_flash_model
    import css_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              present,
    input  css_pkg::css_flash_cmd_t flash_cmd,
    output logic                   flash_ack,
    output logic                   fw_loaded
);
    logic [2:0] age_q;
    // Answer two cycles into a probe, only when fitted.
    // The three-byte firmware read ends a few cycles later.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            age_q     <= 3'h0;
            flash_ack <= 1'b0;
            fw_loaded <= 1'b0;
        end else begin
            age_q     <= (flash_cmd.req || flash_cmd.boot_rd) ? age_q + 3'(age_q != 3'h7) : 3'h0;
            flash_ack <= present && flash_cmd.req && age_q >= 3'h2;
            fw_loaded <= present && flash_cmd.boot_rd && age_q >= 3'h3;
        end
    end
endmodule // css_flash_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the scheme select front end.
// Assumes: Inputs change on the falling edge; the flash wait is ten cycles.
// Notes:   Each scenario restarts the block from reset.
`timescale 1ns/1ps
module tb_top;
    import css_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0, present = 1'b1;
    logic [2:0] strap = 3'h0;
    logic reconfig_req = 1'b0, jtag_active = 1'b0, jtag_disabled = 1'b0;
    logic periph_done = 1'b0, pcie_link_up = 1'b0, image_done = 1'b0, core_update_req = 1'b0;
    logic stream_cfg_valid = 1'b0, word_ready = 1'b0;
    logic [31:0] stream_cfg_word = 32'h0000_0000;
    logic flash_ack, fw_loaded, stream_cfg_ready, word_valid;
    logic [31:0] word_data;
    css_scheme_t scheme;
    css_flash_cmd_t flash_cmd;
    css_status_t status;
    int num_errors = 0, checks = 0, cycles = 0;
    // Watched events by index: ready, addr4, boot read, request, missing, failed, user.
    wire [6:0] evt = {status.user_mode, status.failed, status.mem_missing, flash_cmd.req,
                      flash_cmd.boot_rd, flash_cmd.addr4, stream_cfg_ready};

    css_top #(.WAIT_CYC(10), .FIFO_DEPTH(8)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .scheme_select_strap(strap),
        .reconfig_req(reconfig_req), .jtag_active(jtag_active), .jtag_disabled(jtag_disabled),
        .flash_ack(flash_ack), .fw_loaded(fw_loaded), .periph_done(periph_done),
        .pcie_link_up(pcie_link_up), .image_done(image_done), .core_update_req(core_update_req),
        .stream_cfg_valid(stream_cfg_valid), .stream_cfg_word(stream_cfg_word),
        .stream_cfg_ready(stream_cfg_ready), .word_valid(word_valid), .word_ready(word_ready),
        .word_data(word_data), .scheme(scheme), .flash_cmd(flash_cmd), .status(status));
    css_flash_model i_flash (.ref_clk(ref_clk), .rst_b(rst_b), .present(present),
        .flash_cmd(flash_cmd), .flash_ack(flash_ack), .fw_loaded(fw_loaded));

    always #20 ref_clk = ~ref_clk;

    task automatic give_verdict();
        if (num_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A hang costs one mismatch and ends the run.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Reset for three cycles with the strap and security levels in place.
    task automatic start(input logic [2:0] s, input logic [1:0] jt);
        @(negedge ref_clk);
        rst_b = 1'b0;
        strap = s;
        {jtag_active, jtag_disabled} = jt;
        {periph_done, pcie_link_up, image_done, core_update_req, word_ready} = 5'h00;
        present = 1'b1;
        repeat (3) @(negedge ref_clk);
        rst_b = 1'b1;
    endtask

    // Wait at falling edges for an event, bounded.
    task automatic wait_evt(input int idx, output int n);
        n = 0;
        while (evt[idx] !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        check("event", evt[idx], 32'h0000_0001);
    endtask

    // Present one word and hold it until ready is seen at a rising edge, giving up after 12 rising edges.
    task automatic push(input logic [31:0] w, output bit took);
        took = 1'b0;
        stream_cfg_valid = 1'b1;
        stream_cfg_word = w;
        repeat (12) begin
            @(posedge ref_clk);
            if (stream_cfg_ready === 1'b1) begin
                took = 1'b1;
                break;
            end
        end
        @(negedge ref_clk);
    endtask

    task automatic t_decode();
        css_scheme_t exp_sch [8] = '{CSS_SCH_X32, CSS_SCH_FAST, CSS_SCH_NONE, CSS_SCH_NORMAL,
                                     CSS_SCH_CARD, CSS_SCH_X16, CSS_SCH_X8, CSS_SCH_JTAG};
        for (int i = 0; i < 8; i++) begin
            start(3'(i), 2'h0);
            repeat (3) @(negedge ref_clk);
            strap = ~strap;
            repeat (2) @(negedge ref_clk);
            check("scheme", scheme, exp_sch[i]);
            check("host master", status.host_master, (8'hE1 >> i) & 8'h01);
        end
    endtask

    task automatic t_jtag();
        bit took;
        for (int j = 1; j < 4; j++) begin
            start(3'h0, 2'(j));
            repeat (3) @(negedge ref_clk);
            check("jtag scheme", scheme, (j == 2) ? CSS_SCH_JTAG : CSS_SCH_X32);
            // The strap scheme is still x32 here, so a full-width word must pass intact.
            if (j != 2) begin
                push(32'hA5C3_0F00 + j, took);
                stream_cfg_valid = 1'b0;
                check("x32 took", took, 32'h0000_0001);
                check("x32 word", word_data, 32'hA5C3_0F00 + j);
            end
        end
    endtask

    task automatic t_stream();
        int n;
        int got = 0;
        bit took;
        start(3'h5, 2'h0);
        wait_evt(0, n);
        for (int i = 0; i < 9; i++) begin
            push(32'hFFFF_1000 + i, took);
            got += took;
        end
        stream_cfg_valid = 1'b0;
        check("words taken", got, 32'h0000_0008);
        word_ready = 1'b1;
        for (int i = 0; i < 8; i++) begin
            check("out word", word_data, 32'h0000_1000 + i);
            @(negedge ref_clk);
        end
        check("drained", word_valid, 32'h0000_0000);
        image_done = 1'b1;
        wait_evt(6, n);
        check("pins freed", status.gpio_released, 32'h0000_0001);
        check("ready in user", stream_cfg_ready, 32'h0000_0000);
    endtask

    task automatic t_flash(input logic [2:0] s);
        int n;
        start(s, 2'h0);
        wait_evt(3, n);
        check("wait length", (s == 3'h3) ? (n >= 10) : (n <= 4), 32'h0000_0001);
        wait_evt(2, n);
        check("three-byte", flash_cmd.addr4, 32'h0000_0000);
        wait_evt(1, n);
        check("four-byte", flash_cmd.boot_rd, 32'h0000_0000);
        periph_done = 1'b1;
        pcie_link_up = 1'b1;
        wait_evt(0, n);
        image_done = 1'b1;
        wait_evt(6, n);
        image_done = 1'b0;
        core_update_req = 1'b1;
        wait_evt(0, n);
        check("update keeps flash idle", flash_cmd.req, 32'h0000_0000);
    endtask

    task automatic t_missing();
        int n;
        start(3'h1, 2'h0);
        present = 1'b0;
        wait_evt(4, n);
        // The failed flag follows the missing flag by one cycle.
        @(negedge ref_clk);
        check("failed", status.failed, 32'h0000_0001);
        strap = 3'h5;
        reconfig_req = 1'b1;
        @(negedge ref_clk);
        reconfig_req = 1'b0;
        wait_evt(0, n);
        check("resampled", scheme, CSS_SCH_X16);
    endtask

    initial begin
        t_decode();
        t_jtag();
        t_stream();
        t_flash(3'h3);
        t_flash(3'h1);
        t_missing();
        give_verdict();
    end
endmodule // tb_top
